// [shared/pwm_sync_defines.vh]
// register map and field layout of the frame-sync configuration block
// assumes byte-wide registers, one per aligned 32-bit bus word
`ifndef PWM_SYNC_DEFINES_VH
`define PWM_SYNC_DEFINES_VH
`define DIV_HIGH_ADDR      8'ha6
`define DIV_LOW_CFG_ADDR   8'ha7
`define CTRL_ADDR          8'ha8
`define STATUS_ADDR        8'hac
`define DIV_HIGH_RESET     8'h00
`define DIV_LOW_CFG_RESET  8'h00
`define CTRL_RESET         8'h00
`define DIV_LOW_MSB        7
`define DIV_LOW_LSB        3
`define FREQ_RES_BIT       2
`define HYST_MSB           1
`define HYST_LSB           0
`define CTRL_SYNC_BIT      7
`define CTRL_RES_MSB       1
`define CTRL_RES_LSB       0
`define HYST_OFF           2'b00
`define HYST_RES11         2'b01
`define HYST_RES10         2'b10
`define HYST_RES8          2'b11
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10
`endif

// [src/pwm_sync_decode.v]
// decodes stored configuration into the controls of the pwm core
// assumes register values from the same clock domain
module pwm_sync_decode (
   input  wire [7:0]  div_high_i,
   input  wire [7:0]  div_low_cfg_i,
   input  wire        sync_enable_i,
   output reg  [12:0] lock_divider_o,
   output reg         divider_used_o,
   output reg         use_resistor_o,
   output reg  [3:0]  hyst_lsb_mask_o
);
`include "pwm_sync_defines.vh"
   always @* begin
      // divider high byte above the five upper bits of the low register
      lock_divider_o = {div_high_i,
         div_low_cfg_i[`DIV_LOW_MSB:`DIV_LOW_LSB]};
      divider_used_o = sync_enable_i;
      use_resistor_o = div_low_cfg_i[`FREQ_RES_BIT];
      // one-hot: off, 11-bit, 10-bit, 8-bit hysteresis step
      case (div_low_cfg_i[`HYST_MSB:`HYST_LSB])
         `HYST_OFF:   hyst_lsb_mask_o = 4'b0001;
         `HYST_RES11: hyst_lsb_mask_o = 4'b0010;
         `HYST_RES10: hyst_lsb_mask_o = 4'b0100;
         `HYST_RES8:  hyst_lsb_mask_o = 4'b1000;
         default:     hyst_lsb_mask_o = 4'b0001;
      endcase
   end
endmodule

// [src/pwm_lock_counter.v]
// frame-period counter of the lock loop, counts up to the divider, then restarts from zero
// assumes a one-cycle loop tick enable on the same clock
module pwm_lock_counter #(
   parameter WIDTH = 13
) (
   input  wire             mclk_i,
   input  wire             rst_b_i,
   input  wire             tick_i,
   input  wire             lock_i,
   input  wire [WIDTH-1:0] divider_i,
   output reg              frame_o
);
   reg [WIDTH-1:0] count;
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count   <= {WIDTH{1'b0}};
         frame_o <= 1'b0;
      end else begin
         frame_o <= 1'b0;
         if (!lock_i) begin
            // lock off: count held at zero, the divider is not looked at
            count <= {WIDTH{1'b0}};
         end else if (tick_i) begin
            if (count >= divider_i) begin
               count   <= {WIDTH{1'b0}};
               frame_o <= 1'b1;
            end else begin
               count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule

// [src/pwm_frame_sync_config.v]
// AXI4-Lite register file and lock-loop rate control of the backlight pwm
// assumes a 50 MHz mclk_i, synchronous AXI master, async frame-sync pin
module pwm_frame_sync_config (
   input  wire        mclk_i,
   input  wire        rst_b_i,
   input  wire [9:0]  s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output reg         s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output reg         s_axi_wready_o,
   output reg  [1:0]  s_axi_bresp_o,
   output reg         s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   input  wire [9:0]  s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output reg         s_axi_arready_o,
   output reg  [31:0] s_axi_rdata_o,
   output reg  [1:0]  s_axi_rresp_o,
   output reg         s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   input  wire [1:0]  output_freq_select_i,
   input  wire        frame_sync_i,
   output reg  [12:0] lock_divider_o,
   output reg         lock_enable_o,
   output reg  [3:0]  loop_rate_onehot_o,
   output reg         freq_set_resistor_en_o,
   output reg  [1:0]  output_freq_select_o,
   output reg  [3:0]  hyst_lsb_mask_o,
   output reg         loop_tick_o,
   output reg         frame_edge_o
);
`include "pwm_sync_defines.vh"
   reg  [7:0]  div_high;
   reg  [7:0]  div_low_cfg;
   reg  [7:0]  ctrl;
   reg  [9:0]  aw_addr;
   reg  [7:0]  w_data;
   reg         w_lane0;
   reg         aw_held;
   reg         w_held;
   reg  [2:0]  rate_cnt;
   reg         sync_meta;
   reg         sync_sync;
   reg         sync_last;
   reg         lock_seen;
   wire [12:0] divider;
   wire        divider_used;
   wire        use_resistor;
   wire [3:0]  hyst_mask;
   wire        frame_done;
   reg  [2:0]  rate_top;
   reg         rate_tick;

   // offsets are word indices; byte address is four times the index
   function [7:0] word_index;
      input [9:0] addr;
      begin
         word_index = (addr[1:0] == 2'b00) ? addr[9:2] : 8'hff;
      end
   endfunction

   // true for any index this block answers
   function mapped;
      input [7:0] idx;
      begin
         mapped = (idx == `DIV_HIGH_ADDR) ||
                  (idx == `DIV_LOW_CFG_ADDR) ||
                  (idx == `CTRL_ADDR) ||
                  (idx == `STATUS_ADDR);
      end
   endfunction

   // registers are byte wide, each in the low byte of its word
   function [7:0] read_word;
      input [7:0] idx;
      begin
         case (idx)
            `DIV_HIGH_ADDR:    read_word = div_high;
            `DIV_LOW_CFG_ADDR: read_word = div_low_cfg;
            `CTRL_ADDR:        read_word = ctrl;
            `STATUS_ADDR:      read_word = {6'h00, lock_seen, sync_sync};
            default:           read_word = 8'h00;
         endcase
      end
   endfunction

   // write address and data captured in either order
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_axi_awready_o <= 1'b1;
         s_axi_wready_o  <= 1'b1;
         s_axi_bvalid_o  <= 1'b0;
         s_axi_bresp_o   <= `RESP_OKAY;
         aw_addr         <= 10'h000;
         w_data          <= 8'h00;
         w_lane0         <= 1'b0;
         aw_held         <= 1'b0;
         w_held          <= 1'b0;
         div_high        <= `DIV_HIGH_RESET;
         div_low_cfg     <= `DIV_LOW_CFG_RESET;
         ctrl            <= `CTRL_RESET;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_addr         <= s_axi_awaddr_i;
            aw_held         <= 1'b1;
            s_axi_awready_o <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_data         <= s_axi_wdata_i[7:0];
            w_lane0        <= s_axi_wstrb_i[0];
            w_held         <= 1'b1;
            s_axi_wready_o <= 1'b0;
         end
         if (aw_held && w_held && !s_axi_bvalid_o) begin
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= mapped(word_index(aw_addr)) ?
                              `RESP_OKAY : `RESP_SLVERR;
            if (w_lane0) begin
               case (word_index(aw_addr))
                  `DIV_HIGH_ADDR:    div_high <= w_data;
                  `DIV_LOW_CFG_ADDR: div_low_cfg <= w_data;
                  `CTRL_ADDR:        ctrl <= w_data;
                  default:           ctrl <= ctrl;
               endcase
            end
         end
         if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o  <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
         end
      end
   end

   // read channel: one cycle from address to data
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_axi_arready_o <= 1'b1;
         s_axi_rvalid_o  <= 1'b0;
         s_axi_rdata_o   <= 32'h0000_0000;
         s_axi_rresp_o   <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rdata_o   <= {24'h00_0000,
                                read_word(word_index(s_axi_araddr_i))};
            s_axi_rresp_o   <= mapped(word_index(s_axi_araddr_i)) ?
                               `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
         end
      end
   end

   pwm_sync_decode u_decode (
      .div_high_i      (div_high),
      .div_low_cfg_i   (div_low_cfg),
      .sync_enable_i   (ctrl[`CTRL_SYNC_BIT]),
      .lock_divider_o  (divider),
      .divider_used_o  (divider_used),
      .use_resistor_o  (use_resistor),
      .hyst_lsb_mask_o (hyst_mask)
   );

   // loop tick: 50 MHz divided down; 40 MHz not reachable, runs at clock
   always @* begin
      case (ctrl[`CTRL_RES_MSB:`CTRL_RES_LSB])
         2'b00:   rate_top = 3'd7;
         2'b01:   rate_top = 3'd4;
         2'b10:   rate_top = 3'd1;
         2'b11:   rate_top = 3'd0;
         default: rate_top = 3'd0;
      endcase
      rate_tick = (rate_cnt >= rate_top);
   end

   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rate_cnt <= 3'd0;
      end else if (rate_tick) begin
         rate_cnt <= 3'd0;
      end else begin
         rate_cnt <= rate_cnt + 3'd1;
      end
   end

   pwm_lock_counter #(
      .WIDTH (13)
   ) u_counter (
      .mclk_i    (mclk_i),
      .rst_b_i   (rst_b_i),
      .tick_i    (rate_tick),
      .lock_i    (divider_used),
      .divider_i (divider),
      .frame_o   (frame_done)
   );

   // frame-sync pin passes two flops before edge detection
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync_meta <= 1'b0;
         sync_sync <= 1'b0;
         sync_last <= 1'b0;
         lock_seen <= 1'b0;
      end else begin
         sync_meta <= frame_sync_i;
         sync_sync <= sync_meta;
         sync_last <= sync_sync;
         if (!divider_used) begin
            lock_seen <= 1'b0;
         end else if (frame_done) begin
            lock_seen <= 1'b1;
         end
      end
   end

   // all outputs registered
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lock_divider_o         <= 13'h0000;
         lock_enable_o          <= 1'b0;
         loop_rate_onehot_o     <= 4'b0001;
         freq_set_resistor_en_o <= 1'b0;
         output_freq_select_o   <= 2'b00;
         hyst_lsb_mask_o        <= 4'b0001;
         loop_tick_o            <= 1'b0;
         frame_edge_o           <= 1'b0;
      end else begin
         lock_divider_o     <= divider_used ? divider : 13'h0000;
         lock_enable_o      <= divider_used;
         loop_rate_onehot_o <= 4'b0001 <<
                               ctrl[`CTRL_RES_MSB:`CTRL_RES_LSB];
         freq_set_resistor_en_o <= use_resistor;
         // selected field is passed on only while the resistor is off
         output_freq_select_o <= use_resistor ?
                                 2'b00 : output_freq_select_i;
         hyst_lsb_mask_o <= hyst_mask;
         loop_tick_o     <= rate_tick;
         frame_edge_o    <= divider_used && sync_sync && !sync_last;
      end
   end
endmodule

// [bench/pwm_sync_checker.sv]
// port assertions for the frame-sync configuration block
// assumes one clock and an active-low async reset on the design
module pwm_sync_checker (
   input wire        mclk_i,
   input wire        rst_b_i,
   input wire        s_axi_awvalid_i,
   input wire        s_axi_awready_o,
   input wire        s_axi_wvalid_i,
   input wire        s_axi_wready_o,
   input wire        s_axi_bvalid_o,
   input wire        s_axi_bready_i,
   input wire        s_axi_arvalid_i,
   input wire        s_axi_arready_o,
   input wire [31:0] s_axi_rdata_o,
   input wire        s_axi_rvalid_o,
   input wire        s_axi_rready_i,
   input wire [12:0] lock_divider_o,
   input wire        lock_enable_o,
   input wire [3:0]  loop_rate_onehot_o,
   input wire        freq_set_resistor_en_o,
   input wire [1:0]  output_freq_select_o,
   input wire [3:0]  hyst_lsb_mask_o,
   input wire        frame_edge_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   AST_RATE_ONEHOT: assert property ($onehot(loop_rate_onehot_o))
      else $error("loop rate select not one-hot");
   AST_HYST_ONEHOT: assert property ($onehot(hyst_lsb_mask_o))
      else $error("hysteresis mask not one-hot");
   AST_DIV_UNUSED: assert property ((!lock_enable_o) [*3]
      |-> lock_divider_o == 13'h0000) else $error("divider used while off");
   AST_RES_MUTES_SEL: assert property (freq_set_resistor_en_o [*2]
      |-> output_freq_select_o == 2'h0) else $error("select not muted");
   AST_FRAME_GATED: assert property (frame_edge_o
      |-> lock_enable_o || $past(lock_enable_o))
      else $error("frame edge while sync disabled");
   AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i
      |=> s_axi_bvalid_o) else $error("write response dropped");
   AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i
      |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data not held");
   AST_R_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o
      |=> s_axi_rvalid_o) else $error("read answer late");
   AST_B_ANSWER: assert property (s_axi_awvalid_i && s_axi_awready_o &&
      s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
      else $error("write answer late");
endmodule
bind pwm_frame_sync_config pwm_sync_checker chk (.*);

// [bench/tb_pwm_frame_sync_config.sv]
// self-checking bench for the frame-sync configuration block
// assumes the register map of pwm_sync_defines.vh
`include "pwm_sync_defines.vh"
module tb_pwm_frame_sync_config;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 0, rst_b_i = 0, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0, fsync = 0;
   logic [9:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, d;
   logic [3:0] wstrb = 0;
   logic [1:0] ofs = 0, r;
   wire awready, wready, bvalid, arready, rvalid, lock_en, res_en, fedge;
   wire [1:0] bresp, rresp, ofs_o;
   wire [31:0] rdata;
   wire [12:0] div;
   wire [3:0] rate, hyst;
   int err_total = 0, cmp_count = 0, cyc = 0;
   pwm_frame_sync_config dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .output_freq_select_i(ofs),
      .frame_sync_i(fsync), .lock_divider_o(div), .lock_enable_o(lock_en),
      .loop_rate_onehot_o(rate), .freq_set_resistor_en_o(res_en),
      .output_freq_select_o(ofs_o), .hyst_lsb_mask_o(hyst),
      .loop_tick_o(), .frame_edge_o(fedge));
   initial begin
      forever #10 mclk_i = ~mclk_i;
   end
   task wrap_up;
      $display("mismatches %0d compares %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         wrap_up;
      end
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task wr(input [9:0] a, input [31:0] v, input [3:0] s);
      bit aw, w;
      aw = 1;
      w = 1;
      awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1; wvalid <= 1;
      while (aw || w) begin
         @(posedge mclk_i);
         if (aw && awready) begin aw = 0; awvalid <= 0; end
         if (w && wready) begin w = 0; wvalid <= 0; end
      end
      do @(posedge mclk_i); while (!bvalid);
      bready <= 1;
      @(posedge mclk_i);
      r = bresp;
      bready <= 0;
   endtask
   task rd(input [9:0] a);
      araddr <= a;
      arvalid <= 1;
      do @(posedge mclk_i); while (!arready);
      arvalid <= 0;
      do @(posedge mclk_i); while (!rvalid);
      rready <= 1;
      @(posedge mclk_i);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask
   task idle;
      repeat (3) @(posedge mclk_i);
   endtask
   task t_div;
      rd({`DIV_HIGH_ADDR, 2'b00}); chk("a6 reset", 32'h0000_0000, d);
      chk("hyst reset", 32'h0000_0001, hyst);
      // 5 MHz loop, 60 Hz frame: 5000000 / (26 * 60) = 3205
      wr({`DIV_HIGH_ADDR, 2'b00}, 32'h0000_0064, 4'hf);
      wr({`DIV_LOW_CFG_ADDR, 2'b00}, 32'h0000_0028, 4'hf);
      wr({`DIV_HIGH_ADDR, 2'b00}, 32'h0000_00ff, 4'h0);
      wr({`CTRL_ADDR, 2'b00}, 32'h0000_0080, 4'hf);
      idle; chk("divider", 32'h0000_0c85, div);
      rd({`DIV_HIGH_ADDR, 2'b00}); chk("a6", 32'h0000_0064, d);
      rd({`DIV_LOW_CFG_ADDR, 2'b00}); chk("a7", 32'h0000_0028, d);
      wr({`CTRL_ADDR, 2'b00}, 32'h0000_0000, 4'hf);
      idle; chk("divider off", 32'h0000_0000, div);
      chk("lock enable", 32'h0000_0000, lock_en);
      wr(10'h040, 32'h0000_0001, 4'hf); chk("bresp", `RESP_SLVERR, r);
      rd(10'h040); chk("rresp", `RESP_SLVERR, r);
   endtask
   task t_rate;
      for (int i = 0; i < 4; i++) begin
         wr({`CTRL_ADDR, 2'b00}, 32'h0000_0080 + i, 4'hf);
         fsync <= ~fsync;
         idle; chk("rate", 32'h0000_0001 << i, rate);
         chk("divider kept", 32'h0000_0c85, div);
      end
   endtask
   task t_hyst;
      for (int i = 0; i < 4; i++) begin
         wr({`DIV_LOW_CFG_ADDR, 2'b00}, i, 4'hf);
         idle; chk("hyst", 32'h0000_0001 << i, hyst);
      end
   endtask
   task t_res;
      ofs <= 2'h2;
      wr({`DIV_LOW_CFG_ADDR, 2'b00}, 32'h0000_0000, 4'hf);
      idle; chk("res off", 32'h0000_0000, res_en);
      chk("sel passed", 32'h0000_0002, ofs_o);
      wr({`DIV_LOW_CFG_ADDR, 2'b00}, 32'h0000_0004, 4'hf);
      idle; chk("res on", 32'h0000_0001, res_en);
      chk("sel muted", 32'h0000_0000, ofs_o);
   endtask
   task t_sync;
      int n;
      n = 0;
      fsync <= 0;
      wr({`CTRL_ADDR, 2'b00}, 32'h0000_0080, 4'hf);
      idle;
      fsync <= 1;
      repeat (6) begin
         @(posedge mclk_i);
         if (fedge === 1'b1) n++;
      end
      chk("frame edge on", 32'h0000_0001, n);
      fsync <= 0;
      wr({`CTRL_ADDR, 2'b00}, 32'h0000_0000, 4'hf);
      idle;
      n = 0;
      fsync <= 1;
      repeat (6) begin
         @(posedge mclk_i);
         if (fedge !== 1'b0) n++;
      end
      chk("frame edge off", 32'h0000_0000, n);
   endtask
   initial begin
      repeat (8) @(posedge mclk_i);
      rst_b_i <= 1;
      @(posedge mclk_i);
      t_div;
      t_rate;
      t_hyst;
      t_res;
      t_sync;
      wrap_up;
   end
endmodule
